/* File: logic/uiedr_top.v */
// Operation
// - Y base register holds address bits 10..3; start address appends three zeros.
// - Transactions start at the programmed base; hardware never alters it.
// - Y byte count in bits 6..0, zero is an empty packet.
// - Y count bit 7 is NAK: 0 data ready, 1 empty and NAKed.
// - One 7-bit size field serves X and Y; bit 7 reads zero.
// - Endpoints 1..7 use descriptor entries; endpoint 0 uses four registers.
// - Endpoint 0 buffers fixed: input at FEF8, output at FEF0; the token lookup answers every endpoint 0 token with FEF8.
// - Endpoint 0 registers at indices FF80, FF81, FF82, FF83.
// - Endpoint 0 fields sit where endpoints 1..7 put them.
// - Endpoint 0 input bit 2 enables completion interrupt; resets to 0.
// - Endpoint 0 input bit 3 forces STALL; next SETUP clears it.
// - Endpoint 0 input bit 5 is read-only data toggle; resets 0.
// - Bit 7 enables buffer manager service of the endpoint; resets 0.
// - Endpoint 0 count is 4 bits, resets 0; codes above eight mean eight.
// - Endpoint 0 input count NAK resets to 1, output count NAK resets to 0; 0 means packet ready.
// - Double buffering lets toggle pick X or Y; otherwise X only.
// - While setup-received is set, endpoint 0 answers NAK.
//
// The AHB-Lite slave port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "uiedr_regs.vh"
module uiedr_top (
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata,
   output reg hreadyout,
   output reg hresp,
   input wire tok_valid,
   input wire [2:0] tok_ep,
   input wire ack_valid,
   input wire [2:0] ack_ep,
   input wire setup_rx,
   output wire resp_valid,
   output wire [1:0] resp_code,
   output wire [15:0] resp_addr,
   output wire [6:0] resp_len,
   output wire resp_buf_y,
   output reg irq
);
   // ------------------------------------------------------------
   // Storage
   // ------------------------------------------------------------
   reg [7:0] in0_cfg_r;
   reg [7:0] in0_cnt_r;
   reg [7:0] out0_cfg_r;
   reg [7:0] out0_cnt_r;
   reg [7:0] ep_cfg_r [1:7];
   reg [7:0] ep_xbase_r [1:7];
   reg [7:0] ep_xcnt_r [1:7];
   reg [7:0] ep_ybase_r [1:7];
   reg [7:0] ep_ycnt_r [1:7];
   reg [7:0] ep_size_r [1:7];
   reg [8:0] stat_r;
   reg [8:0] mask_r;
   reg [15:0] idx_r;
   localparam [2:0] ST_IDLE = 3'h1;
   localparam [2:0] ST_WDATA = 3'h2;
   localparam [2:0] ST_RDATA = 3'h4;
   reg [2:0] bus_st_r;
   reg [2:0] bus_st_nxt;
   integer i;

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function [3:0] clamp8;
      input [3:0] c;
      begin
         clamp8 = (c > `UIEDR_EP0_MAX) ? `UIEDR_EP0_MAX : c;
      end
   endfunction

   function sel_y;
      input [7:0] cfg;
      begin
         sel_y = cfg[`UIEDR_B_DOUBLE_BUFFER_ENABLE] & cfg[`UIEDR_B_TOGGLE];
      end
   endfunction

   function [7:0] merge;
      input [7:0] old;
      input [7:0] wd;
      input [7:0] wm;
      begin
         merge = (old & ~wm) | (wd & wm);
      end
   endfunction

   function [15:0] buf_start;
      input [7:0] base;
      begin
         buf_start = {5'h00, base, 3'h0};
      end
   endfunction

   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   wire acc = hsel & htrans[1] & hready & (hsize == 3'b010);
   wire [7:0] wd = hwdata[7:0];
   wire ep_hit = (idx_r[15:6] == `UIEDR_EP_PAGE) & (idx_r[5:3] != 3'h0);
   wire [2:0] wep = idx_r[5:3];
   wire [2:0] slot = idx_r[2:0];
   wire wr_go = (bus_st_r == ST_WDATA);
   wire rd_go = (bus_st_r == ST_RDATA);
   wire [7:0] ack_cfg = ep_cfg_r[ack_ep];

   // ------------------------------------------------------------
   // Interrupt status
   // ------------------------------------------------------------
   reg [8:0] stat_set;
   reg [8:0] stat_clr;
   // A hardware set wins over a write-one clear in the same cycle
   wire [8:0] stat_nxt = (stat_r & ~stat_clr) | stat_set;

   always @* begin
      stat_set = 9'h000;
      stat_set[`UIEDR_B_SETUP] = setup_rx;
      if (ack_valid) begin
         if (ack_ep == 3'h0)
            stat_set[0] = in0_cfg_r[`UIEDR_B_IRQEN];
         else
            stat_set[ack_ep] = ack_cfg[`UIEDR_B_IRQEN];
      end
      stat_clr = 9'h000;
      if (wr_go && idx_r == `UIEDR_IDX_STATUS)
         stat_clr = hwdata[8:0];
   end

   // ------------------------------------------------------------
   // Bus phase: idle, write data phase or read data phase
   // ------------------------------------------------------------
   always @* begin
      bus_st_nxt = ST_IDLE;
      case (bus_st_r)
         ST_IDLE, ST_WDATA: begin
            // A write data phase can overlap the next address phase
            if (acc)
               bus_st_nxt = hwrite ? ST_WDATA : ST_RDATA;
         end
         // The read wait state holds hready low, so no address is taken here
         ST_RDATA: bus_st_nxt = ST_IDLE;
         default: bus_st_nxt = ST_IDLE;
      endcase
   end

   // ------------------------------------------------------------
   // Bus handshake and read data
   // ------------------------------------------------------------
   reg [31:0] rd_val;

   always @* begin
      rd_val = 32'h0000_0000;
      case (idx_r)
         `UIEDR_IDX_IN0_CFG: rd_val[7:0] = in0_cfg_r;
         `UIEDR_IDX_IN0_CNT: rd_val[7:0] = in0_cnt_r;
         `UIEDR_IDX_OUT0_CFG: rd_val[7:0] = out0_cfg_r;
         `UIEDR_IDX_OUT0_CNT: rd_val[7:0] = out0_cnt_r;
         `UIEDR_IDX_STATUS: rd_val[8:0] = stat_r;
         `UIEDR_IDX_MASK: rd_val[8:0] = mask_r;
         default: begin
            if (ep_hit) begin
               case (slot)
                  `UIEDR_SLOT_CFG: rd_val[7:0] = ep_cfg_r[wep];
                  `UIEDR_SLOT_XBASE: rd_val[7:0] = ep_xbase_r[wep];
                  `UIEDR_SLOT_XCNT: rd_val[7:0] = ep_xcnt_r[wep];
                  `UIEDR_SLOT_YBASE: rd_val[7:0] = ep_ybase_r[wep];
                  `UIEDR_SLOT_YCNT: rd_val[7:0] = ep_ycnt_r[wep];
                  `UIEDR_SLOT_SIZE: rd_val[7:0] = ep_size_r[wep];
                  default: rd_val = 32'h0000_0000;
               endcase
            end
         end
      endcase
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         idx_r <= 16'h0000;
         bus_st_r <= ST_IDLE;
         hreadyout <= 1'b1;
         hrdata <= 32'h0000_0000;
         hresp <= 1'b0;
         irq <= 1'b0;
      end else begin
         hresp <= 1'b0;
         bus_st_r <= bus_st_nxt;
         if (acc)
            idx_r <= haddr[17:2];
         if (acc & ~hwrite)
            hreadyout <= 1'b0;
         else if (rd_go)
            hreadyout <= 1'b1;
         if (rd_go)
            hrdata <= rd_val;
         irq <= |(stat_nxt & mask_r);
      end
   end

   // ------------------------------------------------------------
   // Endpoint 0, status and mask registers
   // ------------------------------------------------------------
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         in0_cfg_r <= `UIEDR_RST_IN0_CFG;
         in0_cnt_r <= `UIEDR_RST_IN0_CNT;
         out0_cfg_r <= `UIEDR_RST_OUT0_CFG;
         out0_cnt_r <= `UIEDR_RST_OUT0_CNT;
         stat_r <= 9'h000;
         mask_r <= 9'h000;
      end else begin
         stat_r <= stat_nxt;
         if (setup_rx) begin
            in0_cfg_r[`UIEDR_B_STALL] <= 1'b0;
            out0_cfg_r[`UIEDR_B_STALL] <= 1'b0;
         end
         if (wr_go) begin
            case (idx_r)
               `UIEDR_IDX_IN0_CFG:
                  in0_cfg_r <= merge(in0_cfg_r, wd, `UIEDR_WM_EP0_CFG);
               `UIEDR_IDX_IN0_CNT:
                  in0_cnt_r <= merge(in0_cnt_r, wd, `UIEDR_WM_EP0_CNT);
               `UIEDR_IDX_OUT0_CFG:
                  out0_cfg_r <= merge(out0_cfg_r, wd, `UIEDR_WM_EP0_CFG);
               `UIEDR_IDX_OUT0_CNT:
                  out0_cnt_r <= merge(out0_cnt_r, wd, `UIEDR_WM_EP0_CNT);
               `UIEDR_IDX_MASK:
                  mask_r <= hwdata[8:0];
               default: mask_r <= mask_r;
            endcase
         end
         // Placed after the write so that the hardware update wins a clash
         if (ack_valid && ack_ep == 3'h0) begin
            in0_cnt_r[`UIEDR_B_NAK] <= 1'b1;
            in0_cfg_r[`UIEDR_B_TOGGLE] <= ~in0_cfg_r[`UIEDR_B_TOGGLE];
         end
      end
   end

   // ------------------------------------------------------------
   // Endpoint 1..7 descriptor entries
   // ------------------------------------------------------------
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (i = 1; i < 8; i = i + 1) begin
            ep_cfg_r[i] <= `UIEDR_RST_EP_CFG;
            ep_xbase_r[i] <= `UIEDR_RST_EP_BASE;
            ep_xcnt_r[i] <= `UIEDR_RST_EP_CNT;
            ep_ybase_r[i] <= `UIEDR_RST_EP_BASE;
            ep_ycnt_r[i] <= `UIEDR_RST_EP_CNT;
            ep_size_r[i] <= `UIEDR_RST_EP_SIZE;
         end
      end else begin
         if (wr_go && ep_hit) begin
            case (slot)
               `UIEDR_SLOT_CFG:
                  ep_cfg_r[wep] <= merge(ep_cfg_r[wep], wd, `UIEDR_WM_EP_CFG);
               `UIEDR_SLOT_XBASE: ep_xbase_r[wep] <= wd;
               `UIEDR_SLOT_XCNT: ep_xcnt_r[wep] <= wd;
               `UIEDR_SLOT_YBASE: ep_ybase_r[wep] <= wd;
               `UIEDR_SLOT_YCNT: ep_ycnt_r[wep] <= wd;
               `UIEDR_SLOT_SIZE:
                  ep_size_r[wep] <= merge(ep_size_r[wep], wd, `UIEDR_WM_SIZE);
               default: ep_size_r[wep] <= ep_size_r[wep];
            endcase
         end
         // Placed after the write so that the hardware update wins a clash
         if (ack_valid && ack_ep != 3'h0) begin
            if (sel_y(ack_cfg))
               ep_ycnt_r[ack_ep][`UIEDR_B_NAK] <= 1'b1;
            else
               ep_xcnt_r[ack_ep][`UIEDR_B_NAK] <= 1'b1;
            ep_cfg_r[ack_ep][`UIEDR_B_TOGGLE] <= ~ack_cfg[`UIEDR_B_TOGGLE];
         end
      end
   end

   // ------------------------------------------------------------
   // Token lookup
   // ------------------------------------------------------------
   reg t_en;
   reg t_busy;
   reg t_stall;
   reg t_nak;
   reg t_y;
   reg [15:0] t_addr;
   reg [6:0] t_len;
   reg [7:0] t_cfg;
   reg [7:0] t_cnt;

   always @* begin
      t_cfg = 8'h00;
      t_cnt = 8'h00;
      if (tok_ep == 3'h0) begin
         t_en = in0_cfg_r[`UIEDR_B_ENABLE];
         t_busy = stat_r[`UIEDR_B_SETUP];
         t_stall = in0_cfg_r[`UIEDR_B_STALL];
         t_nak = in0_cnt_r[`UIEDR_B_NAK];
         t_y = 1'b0;
         t_addr = `UIEDR_IN0_BUF;
         t_len = {3'b000, clamp8(in0_cnt_r[3:0])};
      end else begin
         t_cfg = ep_cfg_r[tok_ep];
         t_en = t_cfg[`UIEDR_B_ENABLE];
         t_busy = 1'b0;
         t_stall = t_cfg[`UIEDR_B_STALL];
         t_y = sel_y(t_cfg);
         t_cnt = t_y ? ep_ycnt_r[tok_ep] : ep_xcnt_r[tok_ep];
         t_nak = t_cnt[`UIEDR_B_NAK];
         t_addr = buf_start(t_y ? ep_ybase_r[tok_ep] : ep_xbase_r[tok_ep]);
         t_len = t_cnt[6:0];
      end
   end

   // Answer priority: disabled, setup pending, stall, empty buffer
   uiedr_resp uiedr_resp_inst (
      .hclk(hclk),
      .hresetn(hresetn),
      .tok_valid(tok_valid),
      .ep_enable(t_en),
      .setup_busy(t_busy),
      .ep_stall(t_stall),
      .ep_nak(t_nak),
      .buf_addr(t_addr),
      .buf_len(t_len),
      .use_y(t_y),
      .resp_valid_r(resp_valid),
      .resp_code_r(resp_code),
      .resp_addr_r(resp_addr),
      .resp_len_r(resp_len),
      .resp_buf_y_r(resp_buf_y)
   );
endmodule
`default_nettype wire

/* File: logic/uiedr_regs.vh */
`ifndef UIEDR_REGS_VH
`define UIEDR_REGS_VH
// ------------------------------------------------------------
// Register word indices (byte address = 4 * index)
// ------------------------------------------------------------
`define UIEDR_IDX_IN0_CFG 16'hff80
`define UIEDR_IDX_IN0_CNT 16'hff81
`define UIEDR_IDX_OUT0_CFG 16'hff82
`define UIEDR_IDX_OUT0_CNT 16'hff83
`define UIEDR_IDX_STATUS 16'h00c0
`define UIEDR_IDX_MASK 16'h00c1
// Endpoint 1..7 page: index[15:6], endpoint index[5:3], slot index[2:0]
`define UIEDR_EP_PAGE 10'h002
`define UIEDR_SLOT_CFG 3'h0
`define UIEDR_SLOT_XBASE 3'h1
`define UIEDR_SLOT_XCNT 3'h2
`define UIEDR_SLOT_YBASE 3'h3
`define UIEDR_SLOT_YCNT 3'h4
`define UIEDR_SLOT_SIZE 3'h5
// ------------------------------------------------------------
// Field positions, shared by endpoint 0 and endpoints 1..7
// ------------------------------------------------------------
`define UIEDR_B_ENABLE 7
`define UIEDR_B_TOGGLE 5
`define UIEDR_B_DOUBLE_BUFFER_ENABLE 4
`define UIEDR_B_STALL 3
`define UIEDR_B_IRQEN 2
`define UIEDR_B_NAK 7
`define UIEDR_B_SETUP 8
// ------------------------------------------------------------
// Writable-bit masks
// ------------------------------------------------------------
`define UIEDR_WM_EP0_CFG 8'h8c
`define UIEDR_WM_EP0_CNT 8'h8f
`define UIEDR_WM_EP_CFG 8'hfc
`define UIEDR_WM_SIZE 8'h7f
// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define UIEDR_RST_IN0_CFG 8'h00
`define UIEDR_RST_IN0_CNT 8'h80
`define UIEDR_RST_OUT0_CFG 8'h00
`define UIEDR_RST_OUT0_CNT 8'h00
`define UIEDR_RST_EP_CFG 8'h00
`define UIEDR_RST_EP_BASE 8'h00
`define UIEDR_RST_EP_CNT 8'h80
`define UIEDR_RST_EP_SIZE 8'h00
// ------------------------------------------------------------
// Fixed buffers, counts and answer codes
// ------------------------------------------------------------
`define UIEDR_IN0_BUF 16'hfef8
`define UIEDR_OUT0_BUF 16'hfef0
`define UIEDR_EP0_MAX 4'h8
`define UIEDR_RESP_DATA 2'h0
`define UIEDR_RESP_NAK 2'h1
`define UIEDR_RESP_STALL 2'h2
`define UIEDR_RESP_NONE 2'h3
`endif

/* File: logic/uiedr_resp.v */
`timescale 1ns/100ps
`default_nettype none
`include "uiedr_regs.vh"
module uiedr_resp (
   input wire hclk,
   input wire hresetn,
   input wire tok_valid,
   input wire ep_enable,
   input wire setup_busy,
   input wire ep_stall,
   input wire ep_nak,
   input wire [15:0] buf_addr,
   input wire [6:0] buf_len,
   input wire use_y,
   output reg resp_valid_r,
   output reg [1:0] resp_code_r,
   output reg [15:0] resp_addr_r,
   output reg [6:0] resp_len_r,
   output reg resp_buf_y_r
);
   // ------------------------------------------------------------
   // Token answer, one cycle after the token
   // ------------------------------------------------------------
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         resp_valid_r <= 1'b0;
         resp_code_r <= `UIEDR_RESP_NONE;
         resp_addr_r <= 16'h0000;
         resp_len_r <= 7'h00;
         resp_buf_y_r <= 1'b0;
      end else begin
         resp_valid_r <= tok_valid;
         if (tok_valid) begin
            resp_addr_r <= buf_addr;
            resp_len_r <= buf_len;
            resp_buf_y_r <= use_y;
            if (!ep_enable)
               resp_code_r <= `UIEDR_RESP_NONE;
            else if (setup_busy)
               resp_code_r <= `UIEDR_RESP_NAK;
            else if (ep_stall)
               resp_code_r <= `UIEDR_RESP_STALL;
            else if (ep_nak)
               resp_code_r <= `UIEDR_RESP_NAK;
            else
               resp_code_r <= `UIEDR_RESP_DATA;
         end
      end
   end
endmodule
`default_nettype wire

/* File: verif/uiedr_properties.sv */
`timescale 1ns/100ps
`default_nettype none
module uiedr_properties (
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire hready,
   input wire hreadyout,
   input wire tok_valid,
   input wire [2:0] tok_ep,
   input wire ack_valid,
   input wire [2:0] ack_ep,
   input wire setup_rx,
   input wire resp_valid,
   input wire [1:0] resp_code,
   input wire [15:0] resp_addr,
   input wire [6:0] resp_len,
   input wire resp_buf_y
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   property p_resp_pulse;
      1'b1 |=> resp_valid == $past(tok_valid);
   endproperty
   a_resp_pulse: assert property (p_resp_pulse) else $error("answer pulse off");
   property p_resp_hold;
      !tok_valid |=> $stable(resp_code) && $stable(resp_addr);
   endproperty
   a_resp_hold: assert property (p_resp_hold) else $error("answer moved");
   property p_ep0_addr;
      tok_valid && tok_ep == 3'h0 |=> resp_code != 2'h0 || resp_addr == 16'hfef8;
   endproperty
   a_ep0_addr: assert property (p_ep0_addr) else $error("ep0 buffer address");
   property p_base_pad;
      tok_valid && tok_ep != 3'h0 |=> resp_addr[2:0] == 3'h0 && resp_addr[15:11] == 5'h00;
   endproperty
   a_base_pad: assert property (p_base_pad) else $error("base padding");
   property p_ep0_len;
      tok_valid && tok_ep == 3'h0 |=> resp_len <= 7'h08;
   endproperty
   a_ep0_len: assert property (p_ep0_len) else $error("ep0 length above 8");
   property p_ep0_x;
      tok_valid && tok_ep == 3'h0 |=> !resp_buf_y;
   endproperty
   a_ep0_x: assert property (p_ep0_x) else $error("ep0 used Y buffer");
   property p_setup_nak;
      setup_rx ##2 (tok_valid && tok_ep == 3'h0) |=> resp_code != 2'h0;
   endproperty
   a_setup_nak: assert property (p_setup_nak) else $error("data during setup");
   property p_ack_nak;
      ack_valid && ack_ep == 3'h0 ##2 (tok_valid && tok_ep == 3'h0) |=> resp_code != 2'h0;
   endproperty
   a_ack_nak: assert property (p_ack_nak) else $error("data after ack");
   property p_read_wait;
      hsel && htrans[1] && !hwrite && hready && hsize == 3'h2 |=> !hreadyout ##1 hreadyout;
   endproperty
   a_read_wait: assert property (p_read_wait) else $error("read wait state");
endmodule
`default_nettype wire

/* File: verif/uiedr_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module uiedr_host_model (
   input wire hclk,
   output logic tok_valid,
   output logic [2:0] tok_ep,
   output logic ack_valid,
   output logic [2:0] ack_ep,
   output logic setup_rx
);
   initial begin
      tok_valid = 1'b0;
      ack_valid = 1'b0;
      setup_rx = 1'b0;
      tok_ep = 3'h0;
      ack_ep = 3'h0;
   end
   // ------------------------------------------------------------
   // One-cycle event: 0 token, 1 host ack, 2 setup
   // ------------------------------------------------------------
   task automatic pulse(input logic [1:0] kind, input logic [2:0] ep);
      @(posedge hclk);
      tok_valid <= (kind == 2'h0);
      ack_valid <= (kind == 2'h1);
      setup_rx <= (kind == 2'h2);
      tok_ep <= ep;
      ack_ep <= ep;
      @(posedge hclk);
      tok_valid <= 1'b0;
      ack_valid <= 1'b0;
      setup_rx <= 1'b0;
      // Endpoint lines carry no meaning outside the pulse
      tok_ep <= ~ep;
      ack_ep <= ~ep;
   endtask
endmodule
`default_nettype wire

/* File: verif/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin \
   cmp_count++; \
   if ((s) !== (e)) begin \
      mismatches++; \
      $display("Error %s expected %h seen %h", n, e, s); \
   end \
end
module testbench;
   localparam logic [31:0] A_IC = 32'h3fe00;
   localparam logic [31:0] A_IN = 32'h3fe04;
   localparam logic [31:0] A_ST = 32'h300;
   localparam logic [31:0] A_MK = 32'h304;
   logic hclk, hresetn, hsel, hwrite;
   logic [31:0] haddr, hwdata, q;
   logic [1:0] htrans;
   logic [2:0] hsize;
   wire hready, hresp, tok_valid, ack_valid, setup_rx, resp_valid, resp_buf_y, irq;
   wire [31:0] hrdata;
   wire [2:0] tok_ep, ack_ep;
   wire [1:0] resp_code;
   wire [15:0] resp_addr;
   wire [6:0] resp_len;
   int mismatches, cmp_count;
   uiedr_top uiedr_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .tok_valid(tok_valid),
      .tok_ep(tok_ep), .ack_valid(ack_valid), .ack_ep(ack_ep), .setup_rx(setup_rx),
      .resp_valid(resp_valid), .resp_code(resp_code), .resp_addr(resp_addr),
      .resp_len(resp_len), .resp_buf_y(resp_buf_y), .irq(irq));
   uiedr_host_model uiedr_host_model_inst (.hclk(hclk), .tok_valid(tok_valid),
      .tok_ep(tok_ep), .ack_valid(ack_valid), .ack_ep(ack_ep), .setup_rx(setup_rx));
   function automatic logic [31:0] ep(input int n, input int k);
      return 32'h200 + 32'(n * 32 + k * 4);
   endfunction
   // ------------------------------------------------------------
   // Bus access and event helpers
   // ------------------------------------------------------------
   task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      q = hrdata;
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      bus(a, 1'b1, d);
   endtask
   task automatic rd(input logic [31:0] a, input logic [31:0] e);
      bus(a, 1'b0, 32'h0);
      `CHK($sformatf("reg %h", a), e, q)
      `CHK("hresp", 1'b0, hresp)
   endtask
   task automatic ev(input logic [1:0] kind, input logic [2:0] n);
      uiedr_host_model_inst.pulse(kind, n);
   endtask
   task automatic tk(input logic [2:0] n, input logic [1:0] c);
      ev(2'h0, n);
      @(posedge hclk);
      `CHK("code", c, resp_code)
   endtask
   task automatic final_report;
      $display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      hclk = 1'b0;
      forever #12.5 hclk = ~hclk;
   end
   initial begin
      repeat (5000) @(posedge hclk);
      mismatches++;
      final_report;
   end
   initial begin
      {mismatches, cmp_count} = '0;
      {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
      hsize = 3'h2;
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd(A_IC, 32'h0);
      rd(A_IN, 32'h80);
      rd(32'h3fe08, 32'h0);
      rd(32'h3fe0c, 32'h0);
      rd(A_ST, 32'h0);
      wr(A_IC, 32'hff);
      rd(A_IC, 32'h8c);
      wr(32'h0, 32'hff);
      rd(32'h0, 32'h0);
      wr(ep(3, 3), 32'ha5);
      rd(ep(3, 3), 32'ha5);
      wr(ep(3, 5), 32'hff);
      rd(ep(3, 5), 32'h7f);
      wr(ep(3, 5), 32'h40);
      rd(ep(3, 5), 32'h40);
      wr(A_IC, 32'h0);
      tk(3'h0, 2'h3);
      wr(A_IC, 32'h84);
      wr(A_IN, 32'h05);
      tk(3'h0, 2'h0);
      `CHK("addr", 16'hfef8, resp_addr)
      `CHK("len", 7'h05, resp_len)
      wr(A_IN, 32'h0c);
      tk(3'h0, 2'h0);
      `CHK("len", 7'h08, resp_len)
      wr(A_MK, 32'h1);
      ev(2'h1, 3'h0);
      tk(3'h0, 2'h1);
      rd(A_IN, 32'h8c);
      rd(A_IC, 32'ha4);
      rd(A_ST, 32'h1);
      `CHK("irq", 1'b1, irq)
      wr(A_ST, 32'h1);
      repeat (2) @(posedge hclk);
      `CHK("irq", 1'b0, irq)
      wr(A_IC, 32'h80);
      ev(2'h1, 3'h0);
      rd(A_ST, 32'h0);
      wr(A_IC, 32'h88);
      wr(A_IN, 32'h02);
      tk(3'h0, 2'h2);
      wr(32'h3fe08, 32'hff);
      rd(32'h3fe08, 32'h8c);
      ev(2'h2, 3'h0);
      tk(3'h0, 2'h1);
      rd(A_IC, 32'h80);
      rd(32'h3fe08, 32'h84);
      rd(A_ST, 32'h100);
      `CHK("irq", 1'b0, irq)
      wr(A_ST, 32'h100);
      tk(3'h0, 2'h0);
      wr(ep(2, 0), 32'h90);
      wr(ep(2, 3), 32'h12);
      wr(ep(2, 4), 32'h03);
      tk(3'h2, 2'h1);
      ev(2'h1, 3'h2);
      tk(3'h2, 2'h0);
      `CHK("addr", 16'h0090, resp_addr)
      `CHK("len", 7'h03, resp_len)
      `CHK("ybuf", 1'b1, resp_buf_y)
      ev(2'h1, 3'h2);
      rd(ep(2, 4), 32'h83);
      rd(ep(2, 3), 32'h12);
      rd(ep(2, 0), 32'h90);
      rd(A_ST, 32'h0);
      final_report;
   end
endmodule
bind uiedr_top uiedr_properties uiedr_properties_inst (.hclk(hclk), .hresetn(hresetn),
   .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
   .hreadyout(hreadyout), .tok_valid(tok_valid), .tok_ep(tok_ep), .ack_valid(ack_valid),
   .ack_ep(ack_ep), .setup_rx(setup_rx), .resp_valid(resp_valid), .resp_code(resp_code),
   .resp_addr(resp_addr), .resp_len(resp_len), .resp_buf_y(resp_buf_y));
`default_nettype wire
